/* File: eps_defines.svh */
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH
// control register bit positions
`define EPS_CTL_SPARE 7
`define EPS_CTL_PWRDN 6
`define EPS_CTL_MODE_HI 5
`define EPS_CTL_MODE_LO 4
`define EPS_CTL_AUTO 3
`define EPS_CTL_LATCH 1
`define EPS_CTL_LAUNCH 0
// register map, byte addresses on the 16-bit bus
`define EPS_ADDR_CTL 16'h001b
`define EPS_ADDR_GUARD 16'h001c
`define EPS_ARRAY_BASE 16'h0800
`define EPS_ARRAY_LAST 16'h09ff
`define EPS_NVCFG_ADDR 16'h0040
// reset values
`define EPS_CTL_RESET 8'h00
`define EPS_ERASED_BYTE 8'hff
`define EPS_NVCFG_RESET 8'hf0
// timing, microseconds at a 100 MHz clock
`define EPS_CLK_MHZ 100
`define EPS_PGM_US 10000
`define EPS_BYTE_US 10000
`define EPS_BLOCK_US 10000
`define EPS_BULK_US 10000
`define EPS_AUTO_US 8000
`define EPS_PGM_CYC (`EPS_PGM_US * `EPS_CLK_MHZ)
`define EPS_BYTE_CYC (`EPS_BYTE_US * `EPS_CLK_MHZ)
`define EPS_BLOCK_CYC (`EPS_BLOCK_US * `EPS_CLK_MHZ)
`define EPS_BULK_CYC (`EPS_BULK_US * `EPS_CLK_MHZ)
`define EPS_AUTO_CYC (`EPS_AUTO_US * `EPS_CLK_MHZ)
`endif

/* File: eps_pkg.sv */
package eps_pkg;
	typedef enum logic [1:0] {
		EPS_BYTE_PROGRAM,
		EPS_BYTE_ERASE,
		EPS_BLOCK_ERASE,
		EPS_BULK_ERASE
	} eps_mode_t;
endpackage

/* File: eps_cycle_timer.sv */
`timescale 1ns/10ps
module eps_cycle_timer #(
	parameter int CNT_W = 32
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic [CNT_W-1:0] limit_in,
	// status
	output logic done_out
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic run_reg;
	logic run_next;
	logic done_reg;
	logic done_next;

	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		done_next = 1'b0;
		if (stop_in) begin
			run_next = 1'b0;
			cnt_next = '0;
		end else if (start_in) begin
			run_next = 1'b1;
			cnt_next = '0;
		end else if (run_reg) begin
			cnt_next = cnt_reg + 1'b1;
			// done pulses once when the count reaches limit
			if (cnt_reg + 1'b1 >= limit_in) begin
				run_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
			done_reg <= done_next;
		end
	end

	assign done_out = done_reg;
endmodule

/* File: eps_sequencer.sv */
// What this block does
// - unprogrammed and erased cells read as ones
// - program only clears bits, one byte
// - erase sets bits, byte to whole array
// - protected targets are never changed
// - self-finish ends cycle, clears launch bit
// - latch only writes to array and config byte addresses
// - control writes blocked until array write or read latched
// - later array writes replace latched pair
// - array read returns latch, latches address
// - launch refused without latch and valid address
// - array unreadable during active cycle
// - clearing both clears only launch bit
// - power-down disables array, reset clears it
// - mode bits read/write, reset cleared
// - mode bits select operation, guard suppresses
// - zero to launch ignored once started
// - latch cannot clear while launch set
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "eps_defines.svh"
module eps_sequencer #(
	parameter int ARRAY_DEPTH = 512,
	parameter int BLOCK_SIZE = 128,
	parameter int PGM_CYCLES = `EPS_PGM_CYC,
	parameter int BYTE_CYCLES = `EPS_BYTE_CYC,
	parameter int BLOCK_CYCLES = `EPS_BLOCK_CYC,
	parameter int BULK_CYCLES = `EPS_BULK_CYC,
	parameter int AUTO_CYCLES = `EPS_AUTO_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// register and array bus
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// status
	output logic busy_out,
	output logic array_off_out
);
	localparam int AW = $clog2(ARRAY_DEPTH);
	localparam int NBLK = ARRAY_DEPTH / BLOCK_SIZE;
	localparam int BW = $clog2(BLOCK_SIZE);

	// ****************
	// storage
	// ****************
	// array and config byte model the non-volatile cells: no reset, array powers up erased, config byte powers up f0
	// cells start erased
	logic [7:0] mem_reg [ARRAY_DEPTH] = '{default: `EPS_ERASED_BYTE};
	logic [7:0] nvcfg_reg = `EPS_NVCFG_RESET;
	logic [7:0] guard_reg;
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic [15:0] lat_addr_reg;
	logic [15:0] lat_addr_next;
	logic [7:0] lat_data_reg;
	logic [7:0] lat_data_next;
	logic lat_valid_reg;
	logic lat_valid_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	typedef enum logic [1:0] {EPS_IDLE, EPS_RUN, EPS_HOLD} eps_state_t;
	eps_state_t state_reg;
	eps_state_t state_next;

	// ****************
	// decode
	// ****************
	logic hit_array;
	logic hit_nv;
	logic hit_ctl;
	logic hit_guard;
	logic [AW-1:0] arr_idx;
	logic [AW-1:0] lat_idx;
	logic lat_is_nv;
	logic lat_guarded;
	eps_pkg::eps_mode_t mode;
	logic timer_start;
	logic timer_stop;
	logic timer_done;
	logic [31:0] limit;
	logic do_commit;

	assign hit_array = addr_in >= `EPS_ARRAY_BASE && addr_in <= `EPS_ARRAY_LAST;
	assign hit_nv = addr_in == `EPS_NVCFG_ADDR;
	assign hit_ctl = addr_in == `EPS_ADDR_CTL;
	assign hit_guard = addr_in == `EPS_ADDR_GUARD;
	assign arr_idx = AW'(addr_in - `EPS_ARRAY_BASE);
	assign lat_idx = AW'(lat_addr_reg - `EPS_ARRAY_BASE);
	assign lat_is_nv = lat_addr_reg == `EPS_NVCFG_ADDR;
	assign mode = eps_pkg::eps_mode_t'({ctl_reg[`EPS_CTL_MODE_HI], ctl_reg[`EPS_CTL_MODE_LO]});
	// guard bit of the latched block
	assign lat_guarded = !lat_is_nv && guard_reg[NBLK > 1 ? lat_idx[AW-1:BW] : 0];

	always_comb begin
		case (mode)
			eps_pkg::EPS_BYTE_PROGRAM: limit = 32'(PGM_CYCLES);
			eps_pkg::EPS_BYTE_ERASE: limit = 32'(BYTE_CYCLES);
			eps_pkg::EPS_BLOCK_ERASE: limit = 32'(BLOCK_CYCLES);
			eps_pkg::EPS_BULK_ERASE: limit = 32'(BULK_CYCLES);
			default: limit = 32'(PGM_CYCLES);
		endcase
		// self-finish ends earlier than the nominal time
		if (ctl_reg[`EPS_CTL_AUTO]) begin
			limit = 32'(AUTO_CYCLES);
		end
	end

	// ****************
	// control and latch
	// ****************
	always_comb begin
		ctl_next = ctl_reg;
		lat_addr_next = lat_addr_reg;
		lat_data_next = lat_data_reg;
		lat_valid_next = lat_valid_reg;
		state_next = state_reg;
		rdata_next = 8'h00;
		timer_start = 1'b0;
		timer_stop = 1'b0;
		do_commit = 1'b0;
		if (wr_in && hit_ctl) begin
			if (!(ctl_reg[`EPS_CTL_LATCH] && !lat_valid_reg)) begin
				ctl_next[7:3] = wdata_in[7:3];
				// unused bit 2 has no storage and reads zero
				ctl_next[2] = 1'b0;
				ctl_next[`EPS_CTL_LATCH] = wdata_in[`EPS_CTL_LATCH];
				if (ctl_reg[`EPS_CTL_LAUNCH]) begin
					ctl_next[`EPS_CTL_LATCH] = 1'b1;
				end
				// mode changes mid-cycle would corrupt the array
				if (state_reg != EPS_IDLE) begin
					ctl_next[`EPS_CTL_MODE_HI] = ctl_reg[`EPS_CTL_MODE_HI];
					ctl_next[`EPS_CTL_MODE_LO] = ctl_reg[`EPS_CTL_MODE_LO];
				end
				if (wdata_in[`EPS_CTL_LAUNCH]) begin
					// launch needs latch and valid address
					if (ctl_reg[`EPS_CTL_LATCH] && lat_valid_reg && state_reg == EPS_IDLE) begin
						ctl_next[`EPS_CTL_LAUNCH] = 1'b1;
						state_next = EPS_RUN;
						timer_start = 1'b1;
					end
				end else if (ctl_reg[`EPS_CTL_LAUNCH] && state_reg == EPS_HOLD) begin
					// zero ignored until the sequence finished
					ctl_next[`EPS_CTL_LAUNCH] = 1'b0;
					state_next = EPS_IDLE;
				end
			end
		end
		if (!ctl_next[`EPS_CTL_LATCH]) begin
			lat_valid_next = 1'b0;
		end
		if (wr_in && (hit_array || hit_nv) && ctl_reg[`EPS_CTL_LATCH] && state_reg == EPS_IDLE) begin
			lat_addr_next = addr_in;
			lat_data_next = wdata_in;
			lat_valid_next = 1'b1;
		end
		if (rd_in) begin
			if (hit_ctl) begin
				rdata_next = ctl_reg;
			end else if (hit_guard) begin
				rdata_next = guard_reg;
			end else if (hit_array || hit_nv) begin
				if (ctl_reg[`EPS_CTL_PWRDN] || state_reg == EPS_RUN) begin
					rdata_next = `EPS_ERASED_BYTE;
				end else if (ctl_reg[`EPS_CTL_LATCH]) begin
					rdata_next = lat_data_reg;
					if (state_reg == EPS_IDLE) begin
						lat_addr_next = addr_in;
						lat_valid_next = 1'b1;
					end
				end else if (hit_nv) begin
					rdata_next = nvcfg_reg;
				end else begin
					rdata_next = mem_reg[arr_idx];
				end
			end
		end
		if (state_reg == EPS_RUN && timer_done) begin
			do_commit = 1'b1;
			if (ctl_reg[`EPS_CTL_AUTO]) begin
				ctl_next[`EPS_CTL_LAUNCH] = 1'b0;
				state_next = EPS_IDLE;
			end else begin
				state_next = EPS_HOLD;
			end
		end
		// outside a cycle the timer is held clear so no stale count reaches the next launch
		if (state_next != EPS_RUN) begin
			timer_stop = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctl_reg <= `EPS_CTL_RESET;
			lat_addr_reg <= 16'h0000;
			lat_data_reg <= 8'h00;
			lat_valid_reg <= 1'b0;
			state_reg <= EPS_IDLE;
			rdata_reg <= 8'h00;
		end else begin
			ctl_reg <= ctl_next;
			lat_addr_reg <= lat_addr_next;
			lat_data_reg <= lat_data_next;
			lat_valid_reg <= lat_valid_next;
			state_reg <= state_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************
	// array update
	// ****************
	genvar g;
	generate
		for (g = 0; g < ARRAY_DEPTH; g++) begin : g_cell
			always_ff @(posedge clk_in) begin
				// bulk erase checks each block's own guard, so a guarded latch block does not stop it
				if (do_commit && !lat_is_nv && (!lat_guarded || mode == eps_pkg::EPS_BULK_ERASE)) begin
					case (mode)
						eps_pkg::EPS_BYTE_PROGRAM: begin
							if (lat_idx == AW'(g)) begin
								mem_reg[g] <= mem_reg[g] & lat_data_reg;
							end
						end
						eps_pkg::EPS_BYTE_ERASE: begin
							if (lat_idx == AW'(g)) begin
								mem_reg[g] <= `EPS_ERASED_BYTE;
							end
						end
						eps_pkg::EPS_BLOCK_ERASE: begin
							if (lat_idx[AW-1:BW] == (AW-BW)'(g / BLOCK_SIZE)) begin
								mem_reg[g] <= `EPS_ERASED_BYTE;
							end
						end
						eps_pkg::EPS_BULK_ERASE: begin
							if (!guard_reg[g / BLOCK_SIZE]) begin
								mem_reg[g] <= `EPS_ERASED_BYTE;
							end
						end
						default: begin
							mem_reg[g] <= mem_reg[g];
						end
					endcase
				end
			end
		end
	endgenerate

	// config byte takes byte program and byte erase like an array byte; block and bulk erase leave it unchanged
	always_ff @(posedge clk_in) begin
		if (do_commit && lat_is_nv) begin
			if (mode == eps_pkg::EPS_BYTE_PROGRAM) begin
				nvcfg_reg <= nvcfg_reg & lat_data_reg;
			end else if (mode == eps_pkg::EPS_BYTE_ERASE) begin
				nvcfg_reg <= `EPS_ERASED_BYTE;
			end
		end
	end

	// guard bits follow the config byte low nibble, loaded on a config byte read with latch bit clear, reset clears them
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			guard_reg <= 8'h00;
		end else if (rd_in && hit_nv && !ctl_reg[`EPS_CTL_LATCH]) begin
			guard_reg <= {4'h0, nvcfg_reg[3:0]};
		end else if (state_reg == EPS_IDLE && guard_reg[7]) begin
			guard_reg <= guard_reg;
		end
	end

	eps_cycle_timer #(.CNT_W(32)) u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(timer_start),
		.stop_in(timer_stop),
		.limit_in(limit),
		.done_out(timer_done)
	);

	assign rdata_out = rdata_reg;
	assign busy_out = state_reg == EPS_RUN;
	assign array_off_out = ctl_reg[`EPS_CTL_PWRDN];
endmodule

/* File: eps_sequencer_sva.sv */
`timescale 1ns/10ps
// ****
// port checks
// ****
module eps_sequencer_sva (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// bus and status
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic busy_out,
	input wire logic array_off_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic ctl_rd = rd_in && addr_in == 16'h001b;
	wire logic ctl_wr = wr_in && addr_in == 16'h001b;
	wire logic arr_rd = rd_in && addr_in >= 16'h0800 && addr_in <= 16'h09ff;
	blank_run_a: assert property (busy_out && arr_rd |=> rdata_out == 8'hff)
		else $error("array read during cycle not blank");
	run_bits_a: assert property (busy_out && ctl_rd |=> rdata_out[1:0] == 2'b11)
		else $error("launch or latch bit low during cycle");
	launch_src_a: assert property ($rose(busy_out) |-> $past(ctl_wr && wdata_in[0]))
		else $error("cycle started without launch write");
	run_hold_a: assert property ($rose(busy_out) |-> busy_out[*8])
		else $error("cycle cut short");
	run_end_a: assert property ($rose(busy_out) |-> ##[1:40] !busy_out)
		else $error("cycle did not end");
	off_hold_a: assert property (!ctl_wr |=> $stable(array_off_out))
		else $error("power-down changed without write");
	gap_bit_a: assert property (ctl_rd |=> rdata_out[2] == 1'b0)
		else $error("unused control bit reads one");
	quiet_rd_a: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data outside answer cycle");
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
`include "eps_defines.svh"
module tb_top;
	logic clk_in, rst_n_in, wr_in, rd_in, busy_out, array_off_out;
	logic [15:0] addr_in;
	logic [7:0] wdata_in, rdata_out;
	int n_errors = 0;
	int total_checks = 0;
	localparam logic [15:0] C = `EPS_ADDR_CTL;
	eps_sequencer #(.PGM_CYCLES(24), .BYTE_CYCLES(24), .BLOCK_CYCLES(24), .BULK_CYCLES(24),
		.AUTO_CYCLES(16)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.busy_out(busy_out), .array_off_out(array_off_out));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		cmp(rdata_out, e);
	endtask
	task automatic idle();
		int n;
		n = 0;
		repeat (2) @(posedge clk_in);
		#1;
		while (busy_out !== 1'b0 && n < 100) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		cmp({7'h00, busy_out}, 8'h00);
	endtask
	task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
		wr(C, {2'b00, m, 4'b1010});
		wr(a, d);
		wr(C, {2'b00, m, 4'b1011});
		idle();
		repeat (2) @(posedge clk_in);
		wr(C, 8'h00);
	endtask
	initial begin
		#100000;
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end
	// ****
	// main sequence
	// ****
	// bench has no interrupt source
	initial begin
		rst_n_in = 1'b0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 16'h0000;
		wdata_in = 8'h00;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rdc(C, 8'h00);
		rdc(16'h0800, 8'hff);
		rdc(16'h001c, 8'h00);
		wr(C, 8'hb4);
		rdc(C, 8'hb0);
		wr(C, 8'h40);
		#1;
		cmp({7'h00, array_off_out}, 8'h01);
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
		cmp({7'h00, array_off_out}, 8'h00);
		@(posedge clk_in);
		rst_n_in <= 1'b1;
		rdc(C, 8'h00);
		wr(C, 8'h0b);
		rdc(C, 8'h0a);
		wr(C, 8'h1a);
		wr(16'h0100, 8'h00);
		wr(C, 8'h0b);
		rdc(C, 8'h0a);
		wr(16'h0805, 8'h00);
		wr(16'h0806, 8'haa);
		rdc(16'h0805, 8'haa);
		wr(C, 8'h0b);
		rdc(16'h0806, 8'hff);
		rdc(C, 8'h0b);
		wr(C, 8'h08);
		rdc(C, 8'h0b);
		idle();
		rdc(C, 8'h0a);
		repeat (2) @(posedge clk_in);
		wr(C, 8'h00);
		rdc(16'h0805, 8'haa);
		rdc(16'h0806, 8'hff);
		wr(C, 8'h02);
		wr(16'h0805, 8'hf7);
		wr(C, 8'h03);
		idle();
		rdc(C, 8'h03);
		wr(C, 8'h00);
		rdc(C, 8'h02);
		repeat (2) @(posedge clk_in);
		wr(C, 8'h00);
		rdc(C, 8'h00);
		rdc(16'h0805, 8'ha2);
		op(2'd0, 16'h0880, 8'h00);
		op(2'd0, 16'h0900, 8'h0f);
		op(2'd1, 16'h0805, 8'h00);
		rdc(16'h0805, 8'hff);
		rdc(16'h0880, 8'h00);
		op(2'd2, 16'h08c5, 8'h00);
		rdc(16'h0880, 8'hff);
		rdc(16'h0900, 8'h0f);
		op(2'd3, 16'h09ff, 8'h00);
		rdc(16'h0900, 8'hff);
		op(2'd1, 16'h0040, 8'h00);
		rdc(16'h0040, 8'hff);
		rdc(16'h001c, 8'h0f);
		op(2'd0, 16'h0805, 8'h00);
		rdc(16'h0805, 8'hff);
		op(2'd0, 16'h0040, 8'hf0);
		rdc(16'h0040, 8'hf0);
		rdc(16'h001c, 8'h00);
		end_of_test();
	end
endmodule
bind eps_sequencer eps_sequencer_sva chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .busy_out(busy_out),
	.array_off_out(array_off_out));
